// >>> core/mbld_map.svh
// opcode patterns, field ranges and reset values of the branch/load decoder
`ifndef MBLD_MAP_SVH
`define MBLD_MAP_SVH

// match masks and values, one pair per instruction; the two jump register loads share MBLD_LDJR_MASK
`define MBLD_JTSF_MASK  16'hFFF7
`define MBLD_JTSF_VAL   16'h39B5
`define MBLD_JTSR_MASK  16'hFFE0
`define MBLD_JTSR_VAL   16'h2F20
`define MBLD_RFS_MASK   16'hFFFF
`define MBLD_RFS_VAL    16'h359C
`define MBLD_LDCA_MASK  16'hE007
`define MBLD_LDCA_VAL   16'hA004
`define MBLD_LDCD_MASK  16'hC000
`define MBLD_LDCD_VAL   16'h4000
`define MBLD_LDIRH_MASK 16'hF803
`define MBLD_LDIRH_VAL  16'h3803
`define MBLD_LDIRL_MASK 16'hF803
`define MBLD_LDIRL_VAL  16'h3802
`define MBLD_LDJR_MASK  16'hF003
`define MBLD_FIRST_JUMP_REGISTER_LOAD_VAL  16'h8000
`define MBLD_SECOND_JUMP_REGISTER_LOAD_VAL  16'h9000
`define MBLD_LOAD_MASK  16'hC003
`define MBLD_LOAD_VAL   16'h8002

// operand fields
`define MBLD_F_JPSEL    3
`define MBLD_F_DEST     4:0
`define MBLD_F_CLR      12
`define MBLD_F_SH1      11:10
`define MBLD_F_SH2      9:8
`define MBLD_F_EOC      7:6
`define MBLD_F_ALU      5:3
`define MBLD_F_LDCD_XM  13
`define MBLD_F_LDCD_ADR 5:0
`define MBLD_F_IMM_CLR  10
`define MBLD_F_IMM_VAL  9:2
`define MBLD_F_JR_VAL   11:2
`define MBLD_F_LOAD_ADR 13:8
`define MBLD_F_UC       7:3
`define MBLD_F_LOAD_XM  2
`define MBLD_F_DEST_MSB 4

// shortcut action codes
`define MBLD_SC_KEEP    2'h0
`define MBLD_SC_OFF     2'h1
`define MBLD_SC_ON      2'h2
`define MBLD_SC_TOGGLE  2'h3

// reset values
`define MBLD_PC_RST     10'h000
`define MBLD_OUT_RST    1'b0

`endif

// >>> core/mbld_pkg.sv
// types of the branch/load decoder
package mbld_pkg;

  typedef enum logic [1:0] {
    MBLD_ST_EXEC = 2'b01,
    MBLD_ST_WAIT = 2'b10
  } mbld_state_t;

  typedef logic [9:0]  mbld_addr_t;
  typedef logic [15:0] mbld_word_t;

endpackage

// >>> core/mbld_shortcut.sv
// one shortcut output driven by keep/off/on/toggle actions
`timescale 1ns/1ns
`include "mbld_map.svh"

module mbld_shortcut
  import mbld_pkg::*;
(
  // clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // action strobe
  input  wire logic       apply,
  input  wire logic [1:0] action,
  // output level
  output logic            out_on
);

  typedef struct packed {
    logic on;
  } mbld_sc_state_t;

  mbld_sc_state_t q;
  mbld_sc_state_t d;

  always_comb begin
    d = q;
    if (apply) begin
      unique case (action)
        `MBLD_SC_KEEP:   d.on = q.on;   // RQ8
        `MBLD_SC_OFF:    d.on = 1'b0;   // RQ8
        `MBLD_SC_ON:     d.on = 1'b1;   // RQ8
        `MBLD_SC_TOGGLE: d.on = ~q.on;  // RQ8
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q.on <= `MBLD_OUT_RST;
    end else begin
      q <= d;
    end
  end

  assign out_on = q.on;

endmodule

// >>> core/mbld_decoder.sv
// microcore branch, counter-load, immediate and data-memory load decoder
`timescale 1ns/1ns
`include "mbld_map.svh"

// Overview of operation
// RQ1 - absolute call jumps to selected jump register
// RQ2 - both calls save program counter first
// RQ3 - relative call adds sign-extended 5-bit offset
// RQ4 - absolute call opcode with bit3 register select
// RQ5 - relative call opcode, offset in bits 4..0
// RQ6 - register counter load writes end-of-count, shortcuts
// RQ7 - clear operand zeroes counter, else keeps it
// RQ8 - shortcut: keep, off, on, toggle
// RQ9 - selector codes pick end-of-count one to four
// RQ10 - register counter load opcode and fields
// RQ11 - memory counter load writes word, shortcuts
// RQ12 - indexed mode adds address base
// RQ13 - memory counter load opcode and fields
// RQ14 - upper immediate byte load and encoding
// RQ15 - upper clear flag zeroes upper byte
// RQ16 - lower immediate byte load, clear flag
// RQ17 - first jump register ten-bit load
// RQ18 - second jump register ten-bit load
// RQ19 - memory load into selected microcore register
// RQ20 - return reloads counter from return holder
module mbld_decoder
  import mbld_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // code memory fetch
  output mbld_addr_t       code_addr,
  input  wire logic        instr_valid,
  input  wire mbld_word_t  instr,
  output logic             instr_ready,
  // arithmetic register read port
  output logic [2:0]       alu_sel,
  input  wire mbld_word_t  alu_rdata,
  // data memory read port
  input  wire logic [5:0]  addr_base,
  output logic             dram_rd,
  output logic [5:0]       dram_addr,
  input  wire logic        dram_rvalid,
  input  wire mbld_word_t  dram_rdata,
  // counters
  output logic             eoc_wr,
  output logic [1:0]       eoc_sel,
  output mbld_word_t       eoc_value,
  output logic [3:0]       counter_clear,
  output mbld_word_t       first_end_of_count,
  output mbld_word_t       second_end_of_count,
  output mbld_word_t       third_end_of_count,
  output mbld_word_t       fourth_end_of_count,
  // shortcut outputs
  output logic             first_shortcut_out,
  output logic             second_shortcut_out,
  // microcore register write port
  output logic             uc_wr,
  output logic [4:0]       uc_sel,
  output mbld_word_t       uc_data,
  // visible program state
  output mbld_addr_t       micro_program_counter,
  output mbld_addr_t       return_holder,
  output mbld_word_t       first_jump_register,
  output mbld_word_t       second_jump_register,
  output mbld_word_t       immediate_value_register,
  output logic             unknown_instr
);

  typedef struct packed {
    mbld_state_t      st;
    mbld_addr_t       pc;
    mbld_addr_t       aux;
    mbld_word_t       jr1;
    mbld_word_t       jr2;
    mbld_word_t       ir;
    logic [3:0][15:0] eoc;
    // operands held while a memory read is outstanding
    logic             p_to_eoc;
    logic [1:0]       p_sel;
    logic             p_clr;
    logic [1:0]       p_a1;
    logic [1:0]       p_a2;
    logic [4:0]       p_uc;
    // registered outputs
    logic             dram_rd;
    logic [5:0]       dram_addr;
    logic             eoc_wr;
    logic [1:0]       eoc_sel;
    mbld_word_t       eoc_val;
    logic [3:0]       clr;
    logic             sc_go;
    logic [1:0]       sc_a1;
    logic [1:0]       sc_a2;
    logic             uc_wr;
    logic [4:0]       uc_sel;
    mbld_word_t       uc_data;
    logic             bad;
  } mbld_core_state_t;

  mbld_core_state_t q;
  mbld_core_state_t d;

  function automatic logic is_op(input mbld_word_t w, input mbld_word_t m,
                                 input mbld_word_t v);
    is_op = ((w & m) == v);
  endfunction

  // wraps inside the 6-bit data memory space
  function automatic logic [5:0] ram_ea(input logic [5:0] a, input logic xm,
                                        input logic [5:0] base);
    ram_ea = xm ? 6'(a + base) : a;  // RQ12
  endfunction

  function automatic mbld_addr_t sext5(input logic [4:0] v);
    sext5 = {{5{v[`MBLD_F_DEST_MSB]}}, v};
  endfunction

  // counter write request gathered from either load path
  logic       go;
  logic [1:0] g_sel;
  logic       g_clr;
  logic [1:0] g_a1;
  logic [1:0] g_a2;
  mbld_word_t g_val;
  mbld_addr_t pc_inc;

  assign pc_inc = q.pc + 10'h001;

  always_comb begin
    d = q;
    d.dram_rd = 1'b0;
    d.eoc_wr = 1'b0;
    d.clr = 4'h0;
    d.sc_go = 1'b0;
    d.uc_wr = 1'b0;
    d.bad = 1'b0;
    go = 1'b0;
    g_sel = instr[`MBLD_F_EOC];
    g_clr = instr[`MBLD_F_CLR];
    g_a1 = instr[`MBLD_F_SH1];
    g_a2 = instr[`MBLD_F_SH2];
    g_val = alu_rdata;
    unique case (q.st)
      MBLD_ST_EXEC: begin
        if (instr_valid) begin
          d.pc = pc_inc;
          if (is_op(instr, `MBLD_JTSF_MASK, `MBLD_JTSF_VAL)) begin  // RQ4
            d.aux = pc_inc;  // RQ2
            d.pc = instr[`MBLD_F_JPSEL] ? q.jr2[9:0] : q.jr1[9:0];  // RQ1
          end else if (is_op(instr, `MBLD_JTSR_MASK, `MBLD_JTSR_VAL)) begin  // RQ5
            d.aux = pc_inc;  // RQ2
            d.pc = q.pc + sext5(instr[`MBLD_F_DEST]);  // RQ3
          end else if (is_op(instr, `MBLD_RFS_MASK, `MBLD_RFS_VAL)) begin
            d.pc = q.aux;  // RQ20
          end else if (is_op(instr, `MBLD_LDCA_MASK, `MBLD_LDCA_VAL)) begin  // RQ10
            go = 1'b1;  // RQ6
          end else if (is_op(instr, `MBLD_LDCD_MASK, `MBLD_LDCD_VAL)) begin  // RQ13
            // program counter holds until the word returns
            d.pc = q.pc;
            d.st = MBLD_ST_WAIT;
            d.dram_rd = 1'b1;
            d.dram_addr = ram_ea(instr[`MBLD_F_LDCD_ADR], instr[`MBLD_F_LDCD_XM],
                                 addr_base);  // RQ12
            d.p_to_eoc = 1'b1;
            d.p_sel = instr[`MBLD_F_EOC];
            d.p_clr = instr[`MBLD_F_CLR];
            d.p_a1 = instr[`MBLD_F_SH1];
            d.p_a2 = instr[`MBLD_F_SH2];
          end else if (is_op(instr, `MBLD_LDIRH_MASK, `MBLD_LDIRH_VAL)) begin
            d.ir[15:8] = instr[`MBLD_F_IMM_CLR] ? 8'h00
                                                : instr[`MBLD_F_IMM_VAL];  // RQ14 RQ15
          end else if (is_op(instr, `MBLD_LDIRL_MASK, `MBLD_LDIRL_VAL)) begin
            d.ir[7:0] = instr[`MBLD_F_IMM_CLR] ? 8'h00
                                               : instr[`MBLD_F_IMM_VAL];  // RQ16
          end else if (is_op(instr, `MBLD_LDJR_MASK, `MBLD_FIRST_JUMP_REGISTER_LOAD_VAL)) begin
            d.jr1 = {6'h00, instr[`MBLD_F_JR_VAL]};  // RQ17
          end else if (is_op(instr, `MBLD_LDJR_MASK, `MBLD_SECOND_JUMP_REGISTER_LOAD_VAL)) begin
            d.jr2 = {6'h00, instr[`MBLD_F_JR_VAL]};  // RQ18
          end else if (is_op(instr, `MBLD_LOAD_MASK, `MBLD_LOAD_VAL)) begin
            d.pc = q.pc;
            d.st = MBLD_ST_WAIT;
            d.dram_rd = 1'b1;
            d.dram_addr = ram_ea(instr[`MBLD_F_LOAD_ADR], instr[`MBLD_F_LOAD_XM],
                                 addr_base);  // RQ19 RQ12
            d.p_to_eoc = 1'b0;
            d.p_uc = instr[`MBLD_F_UC];
          end else begin
            // other opcodes belong to neighbouring units; flag unknown_instr and step on
            d.bad = 1'b1;
          end
        end
      end
      MBLD_ST_WAIT: begin
        if (dram_rvalid) begin
          d.st = MBLD_ST_EXEC;
          d.pc = pc_inc;
          if (q.p_to_eoc) begin
            go = 1'b1;  // RQ11
            g_sel = q.p_sel;
            g_clr = q.p_clr;
            g_a1 = q.p_a1;
            g_a2 = q.p_a2;
            g_val = dram_rdata;
          end else begin
            d.uc_wr = 1'b1;  // RQ19
            d.uc_sel = q.p_uc;
            d.uc_data = dram_rdata;
          end
        end
      end
      default: begin
        d.st = MBLD_ST_EXEC;
      end
    endcase
    if (go) begin
      d.eoc[g_sel] = g_val;  // RQ9
      d.eoc_wr = 1'b1;
      d.eoc_sel = g_sel;
      d.eoc_val = g_val;
      // clear=0 leaves the running count alone
      d.clr[g_sel] = g_clr;  // RQ7
      d.sc_go = 1'b1;
      d.sc_a1 = g_a1;
      d.sc_a2 = g_a2;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.st <= MBLD_ST_EXEC;
      q.pc <= `MBLD_PC_RST;
      q.aux <= `MBLD_PC_RST;
    end else begin
      q <= d;
    end
  end

  // shortcut strobe is registered with the counter write; outputs change one cycle after it
  mbld_shortcut u_sc1 (
    .clk    (clk),
    .rst    (rst),
    .apply  (q.sc_go),
    .action (q.sc_a1),
    .out_on (first_shortcut_out)
  );

  mbld_shortcut u_sc2 (
    .clk    (clk),
    .rst    (rst),
    .apply  (q.sc_go),
    .action (q.sc_a2),
    .out_on (second_shortcut_out)
  );

  assign code_addr                = q.pc;
  assign instr_ready              = (q.st == MBLD_ST_EXEC);
  assign alu_sel                  = instr[`MBLD_F_ALU];
  assign dram_rd                  = q.dram_rd;
  assign dram_addr                = q.dram_addr;
  assign eoc_wr                   = q.eoc_wr;
  assign eoc_sel                  = q.eoc_sel;
  assign eoc_value                = q.eoc_val;
  assign counter_clear            = q.clr;
  assign first_end_of_count       = q.eoc[0];
  assign second_end_of_count      = q.eoc[1];
  assign third_end_of_count       = q.eoc[2];
  assign fourth_end_of_count      = q.eoc[3];
  assign uc_wr                    = q.uc_wr;
  assign uc_sel                   = q.uc_sel;
  assign uc_data                  = q.uc_data;
  assign micro_program_counter    = q.pc;
  assign return_holder            = q.aux;
  assign first_jump_register      = q.jr1;
  assign second_jump_register     = q.jr2;
  assign immediate_value_register = q.ir;
  assign unknown_instr            = q.bad;

endmodule

// >>> verif/mbld_decoder_properties.sv
// port-level checks of the branch/load decoder
`timescale 1ns/1ns
`include "mbld_map.svh"

module mbld_decoder_properties
  import mbld_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // fetch and data memory
  input wire logic       instr_valid,
  input wire mbld_word_t instr,
  input wire logic       instr_ready,
  input wire mbld_word_t alu_rdata,
  input wire logic [5:0] addr_base,
  input wire logic       dram_rd,
  input wire logic [5:0] dram_addr,
  // counters
  input wire logic       eoc_wr,
  input wire logic [1:0] eoc_sel,
  input wire mbld_word_t eoc_value,
  input wire logic [3:0] counter_clear,
  // program state
  input wire mbld_addr_t micro_program_counter,
  input wire mbld_addr_t return_holder,
  input wire mbld_word_t first_jump_register,
  input wire mbld_word_t second_jump_register
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic tk;
  logic call_tk;
  assign tk = instr_valid & instr_ready;
  assign call_tk = tk && ((instr & `MBLD_JTSF_MASK) == `MBLD_JTSF_VAL
                   || (instr & `MBLD_JTSR_MASK) == `MBLD_JTSR_VAL);

  chk_abs_call: assert property (tk && (instr & `MBLD_JTSF_MASK) == `MBLD_JTSF_VAL
    |=> micro_program_counter == ($past(instr[3]) ? $past(second_jump_register[9:0])
    : $past(first_jump_register[9:0]))) else $error("absolute call target wrong");
  chk_call_save: assert property (call_tk
    |=> return_holder == $past(micro_program_counter) + 10'h001)
    else $error("return holder not saved");
  chk_rel_call: assert property (tk && (instr & `MBLD_JTSR_MASK) == `MBLD_JTSR_VAL
    |=> micro_program_counter == $past(micro_program_counter)
    + {{5{$past(instr[4])}}, $past(instr[4:0])}) else $error("relative call target wrong");
  chk_ret_reload: assert property (tk && instr == `MBLD_RFS_VAL
    |=> micro_program_counter == $past(return_holder)) else $error("return target wrong");
  chk_ldca_write: assert property (tk && (instr & `MBLD_LDCA_MASK) == `MBLD_LDCA_VAL
    |=> eoc_wr && eoc_value == $past(alu_rdata) && eoc_sel == $past(instr[7:6])
    && counter_clear == ($past(instr[12]) ? 4'h1 << $past(instr[7:6]) : 4'h0))
    else $error("register counter load wrong");
  chk_clear_pulse: assert property (counter_clear != 4'h0
    |-> eoc_wr && counter_clear == 4'h1 << eoc_sel) else $error("stray counter clear");
  chk_mem_addr: assert property (tk && (instr & `MBLD_LDCD_MASK) == `MBLD_LDCD_VAL
    |=> dram_rd && !instr_ready && dram_addr == ($past(instr[13])
    ? $past(instr[5:0]) + $past(addr_base) : $past(instr[5:0])))
    else $error("data memory address wrong");
  chk_jr_load: assert property (tk && (instr & `MBLD_LDJR_MASK) == `MBLD_FIRST_JUMP_REGISTER_LOAD_VAL
    |=> first_jump_register == {6'h00, $past(instr[11:2])}) else $error("jump load wrong");
endmodule

bind mbld_decoder mbld_decoder_properties u_props (.*);

// >>> verif/mbld_decoder_tb.sv
// self-checking bench for the branch/load decoder
`timescale 1ns/1ns
`include "mbld_map.svh"

module mbld_decoder_tb
  import mbld_pkg::*;
;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       instr_valid = 1'b0;
  logic       dram_rvalid = 1'b0;
  logic [5:0] addr_base = 6'h3A;
  mbld_word_t instr = 16'h0000;
  mbld_word_t dram_rdata = 16'h0000;
  mbld_word_t alu_rdata;
  mbld_addr_t code_addr, micro_program_counter, return_holder, pc;
  logic       instr_ready, dram_rd, eoc_wr, uc_wr, unknown_instr, o1, o2;
  logic       first_shortcut_out, second_shortcut_out;
  logic [2:0] alu_sel, r;
  logic [5:0] dram_addr;
  logic [1:0] eoc_sel, e2;
  logic [3:0] counter_clear;
  logic [4:0] uc_sel;
  mbld_word_t eoc_value, uc_data, first_jump_register, second_jump_register;
  mbld_word_t immediate_value_register, first_end_of_count, second_end_of_count;
  mbld_word_t third_end_of_count, fourth_end_of_count;
  mbld_word_t eocs [4];
  logic [1:0] s1t [4] = '{2'h2, 2'h0, 2'h1, 2'h3};
  logic [1:0] s2t [4] = '{2'h3, 2'h1, 2'h0, 2'h2};
  int         n_mismatch = 0;
  int         n_compared = 0;

  always #10 clk = ~clk;
  // register file answers in the same cycle, value tagged by its index
  assign alu_rdata = {alu_sel, 13'h0A5C};
  always_comb eocs = '{first_end_of_count, second_end_of_count, third_end_of_count,
                       fourth_end_of_count};
  mbld_decoder uut (.*);

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic issue(input mbld_word_t iw);
    @(posedge clk);
    instr <= iw;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    #1;
  endtask

  task automatic run(input mbld_word_t iw, input mbld_addr_t npc);
    issue(iw);
    chk("pc", npc, micro_program_counter);
    chk("code_addr", npc, code_addr);
    pc = npc;
  endtask

  // memory answers after dl extra cycles; ready is checked low once, the cycle before it answers
  task automatic mem(input mbld_word_t iw, input logic [5:0] a, input mbld_word_t d,
                     input int dl);
    issue(iw);
    chk("dram_rd", 1'b1, dram_rd);
    chk("dram_addr", a, dram_addr);
    repeat (dl) @(posedge clk);
    chk("ready", 1'b0, instr_ready);
    @(posedge clk);
    dram_rvalid <= 1'b1;
    dram_rdata <= d;
    @(posedge clk);
    dram_rvalid <= 1'b0;
    #1;
    pc = pc + 10'h001;
    chk("pc", pc, micro_program_counter);
  endtask

  function automatic logic act(input logic o, input logic [1:0] a);
    return a == 2'h0 ? o : (a == 2'h3 ? ~o : a[1]);
  endfunction

  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (4000) @(posedge clk);
    n_mismatch++;
    $display("Error watchdog expected done seen hang");
    finish_test;
  end

  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("pc_rst", 10'h000, micro_program_counter);
    pc = 10'h000;
    o1 = 1'b0;
    o2 = 1'b0;
    run({4'h8, 10'h2C5, 2'b00}, 10'h001);
    chk("jr1", 16'h02C5, first_jump_register);
    run({4'h9, 10'h3FF, 2'b00}, 10'h002);
    chk("jr2", 16'h03FF, second_jump_register);
    run(16'h39B5, 10'h2C5);
    chk("holder", 10'h003, return_holder);
    run({11'h179, 5'h10}, 10'h2B5);
    chk("holder", 10'h2C6, return_holder);
    run(16'h359C, 10'h2C6);
    run(16'h39BD, 10'h3FF);
    run({11'h179, 5'h0F}, 10'h00E);
    chk("holder", 10'h000, return_holder);
    $display("test calls done");
    run({5'b00111, 1'b0, 8'hA5, 2'b11}, pc + 10'h001);
    chk("ir", 16'hA500, immediate_value_register);
    run({5'b00111, 1'b0, 8'h3C, 2'b10}, pc + 10'h001);
    chk("ir", 16'hA53C, immediate_value_register);
    run({5'b00111, 1'b1, 8'hFF, 2'b11}, pc + 10'h001);
    chk("ir", 16'h003C, immediate_value_register);
    run({5'b00111, 1'b1, 8'hFF, 2'b10}, pc + 10'h001);
    chk("ir", 16'h0000, immediate_value_register);
    $display("test immediate done");
    for (int e = 0; e < 4; e++) begin
      e2 = 2'(e);
      r = 3'(e + 3);
      run({3'b101, e2[0], s1t[e], s2t[e], e2, r, 3'b100}, pc + 10'h001);
      chk("eoc_wr", 1'b1, eoc_wr);
      chk("eoc_sel", e2, eoc_sel);
      chk("eoc_reg", {r, 13'h0A5C}, eocs[e]);
      chk("clear", e2[0] ? 4'h1 << e2 : 4'h0, counter_clear);
      #20;
      o1 = act(o1, s1t[e]);
      o2 = act(o2, s2t[e]);
      chk("sc1", o1, first_shortcut_out);
      chk("sc2", o2, second_shortcut_out);
    end
    $display("test counters done");
    mem({4'b0101, 4'h0, 2'h2, 6'h21}, 6'h21, 16'hD00D, 0);
    chk("third_end_of_count", 16'hD00D, third_end_of_count);
    chk("clear", 4'h4, counter_clear);
    mem({4'b0110, 4'h7, 2'h3, 6'h0C}, 6'h06, 16'hBEE5, 3);
    chk("fourth_end_of_count", 16'hBEE5, fourth_end_of_count);
    chk("clear", 4'h0, counter_clear);
    #20;
    chk("sc", {act(o1, 2'h1), act(o2, 2'h3)}, {first_shortcut_out, second_shortcut_out});
    mem({2'b10, 6'h3F, 5'h1B, 1'b0, 2'b10}, 6'h3F, 16'h7E81, 1);
    chk("uc", 6'h3B, {uc_wr, uc_sel});
    chk("uc_data", 16'h7E81, uc_data);
    mem({2'b10, 6'h0C, 5'h04, 1'b1, 2'b10}, 6'h06, 16'h0F0F, 0);
    chk("uc_data", 16'h0F0F, uc_data);
    chk("unknown", 1'b0, unknown_instr);
    run(16'h0000, pc + 10'h001);
    chk("unknown", 1'b1, unknown_instr);
    $display("test memory done");
    finish_test;
  end
endmodule
